// ### logic/tbt_err_cnt.v
// saturating errored-nibble counter for packet self-test
// assumes restart is a one-cycle pulse and err is one pulse per errored nibble
`timescale 1ns/1ps
`default_nettype none

module tbt_err_cnt #(
	parameter WIDTH = 8
) (
	input wire clk,
	input wire srst,
	input wire clk_en,
	input wire restart,
	input wire run,
	input wire err,
	output reg [WIDTH-1:0] count_reg
);

	wire at_max;

	assign at_max = &count_reg;

	always @(posedge clk)
	begin
		if (srst)
		begin
			count_reg <= {WIDTH{1'b0}};
		end
		else if (clk_en)
		begin
			if (restart)
			begin
				count_reg <= {WIDTH{1'b0}};
			end
			else if (run && err && !at_max)
			begin
				// sticks at all ones so a long run cannot fake a low count
				count_reg <= count_reg + {{(WIDTH-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule

`default_nettype wire

// ### logic/tbt_gap_timer.v
// sequencer that spaces 10 Mb test sequences by a selectable gap
// assumes seq_done is a one-cycle pulse from the pattern shifter at sequence end
`timescale 1ns/1ps
`default_nettype none

module tbt_gap_timer #(
	parameter CNT_W = 9,
	parameter [CNT_W-1:0] SHORT_CYC = 9'h0C8,
	parameter [CNT_W-1:0] LONG_CYC = 9'h12C
) (
	input wire clk,
	input wire srst,
	input wire clk_en,
	input wire enable,
	input wire long_sel,
	input wire seq_done,
	output reg seq_start_reg,
	output reg gap_busy_reg
);

	localparam [1:0] ST_OFF = 2'h0;
	localparam [1:0] ST_SEQ = 2'h1;
	localparam [1:0] ST_GAP = 2'h2;

	reg [1:0] state_reg;
	reg [CNT_W-1:0] cnt_reg;

	always @(posedge clk)
	begin
		if (srst)
		begin
			state_reg <= ST_OFF;
			cnt_reg <= {CNT_W{1'b0}};
			seq_start_reg <= 1'b0;
			gap_busy_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			seq_start_reg <= 1'b0;
			if (!enable)
			begin
				state_reg <= ST_OFF;
				gap_busy_reg <= 1'b0;
			end
			else
			begin
				case (state_reg)
					ST_OFF:
					begin
						seq_start_reg <= 1'b1;
						state_reg <= ST_SEQ;
					end
					ST_SEQ:
					begin
						if (seq_done)
						begin
							// gap length is sampled at sequence end, not mid-gap
							cnt_reg <= long_sel ? LONG_CYC : SHORT_CYC;
							gap_busy_reg <= 1'b1;
							state_reg <= ST_GAP;
						end
					end
					ST_GAP:
					begin
						cnt_reg <= cnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
						if (cnt_reg == {{(CNT_W-1){1'b0}}, 1'b1})
						begin
							seq_start_reg <= 1'b1;
							gap_busy_reg <= 1'b0;
							state_reg <= ST_SEQ;
						end
					end
					default:
					begin
						state_reg <= ST_OFF;
					end
				endcase
			end
		end
	end

endmodule

`default_nettype wire

// ### logic/tbt_map.vh
// constants for the 10BASE-T control/status and test-pattern register pair
// assumes a 20 MHz core clock and a management front end that gives word strobes
// Functional notes
// - bits 11:9 hold squelch-on threshold code, reset 100 selects 330 mV peak
// - half-duplex 10 Mb echoes transmit data into receive path by default
// - echo disable bit suppresses that echo; general loopback stays untouched
// - link pulse disable bit 7 stops normal link pulses; 0 sends them, here only at 10 Mb with test-pattern enable bit 4 clear
// - forced link bit 6 reports good 10 Mb link; 0 follows detection
// - bit 4 is read-only latched-high inverted polarity, mirrored to status bit 12
// - reading control/status clears both polarity copies; status read leaves them
// - heartbeat disable bit 1 acts only in half-duplex 10 Mb
// - at 100 Mb or full duplex heartbeat stays off regardless
// - jabber disable bit 0 applies only to 10 Mb operation
// - self-test counts errored nibbles in read-only counter bits 15:8
// - error counter clears on self-test restart and saturates at maximum
// - continuous bit 5 makes self-test send unbroken pseudo-random data
// - test-pattern enable bit 4 turns the 10 Mb pattern generator on/off
// - gap between test sequences is 15 us when bit 2 set, else 10 us
// - pattern select 00/01 data with EOP0/EOP1, 10 link pulses, 11 tone
// - self-test pass flag latches its result and clears when self-test stops
`ifndef TBT_MAP_VH
`define TBT_MAP_VH

// register offsets on the management word address
`define TBT_ADDR_W 5
`define TBT_OFS_CTRL_STATUS 5'h1A
`define TBT_OFS_PATTERN_EXT 5'h1B

// control/status layout
`define TBT_SQUELCH_HI 11
`define TBT_SQUELCH_LO 9
`define TBT_ECHO_DIS_BIT 8
`define TBT_NLP_DIS_BIT 7
`define TBT_FORCE_LINK_BIT 6
`define TBT_POLARITY_BIT 4
`define TBT_SQE_DIS_BIT 1
`define TBT_GUARD_DIS_BIT 0
`define TBT_CS_RESET 16'h0804
`define TBT_CS_WR_MASK 16'hFFEF

// test-pattern / self-test extension layout
`define TBT_ERRCNT_HI 15
`define TBT_ERRCNT_LO 8
`define TBT_CONT_BIT 5
`define TBT_PAT_EN_BIT 4
`define TBT_GAP_SEL_BIT 2
`define TBT_PAT_SEL_HI 1
`define TBT_PAT_SEL_LO 0
`define TBT_PX_RESET 16'h0000
`define TBT_PX_WR_MASK 16'h00FF

// pattern codes
`define TBT_PAT_EOP0 2'h0
`define TBT_PAT_EOP1 2'h1
`define TBT_PAT_NLP 2'h2
`define TBT_PAT_TONE 2'h3

// timing
`define TBT_CLK_PERIOD_NS 50
`define TBT_GAP_SHORT_NS 10000
`define TBT_GAP_LONG_NS 15000
`define TBT_GAP_CNT_W 9

`endif

// ### logic/tbt_regs.v
// 10BASE-T control/status and test-pattern/self-test extension registers
// assumes the management front end turns serial frames into single-cycle word
// strobes, and that status inputs are synchronous to clk
`timescale 1ns/1ps
`default_nettype none
`include "tbt_map.vh"

module tbt_regs (
	input wire clk,
	input wire srst,
	input wire clk_en,
	input wire [`TBT_ADDR_W-1:0] reg_addr,
	input wire reg_wr_en,
	input wire reg_rd_en,
	input wire [15:0] reg_wdata,
	input wire half_duplex,
	input wire speed_100,
	input wire link_detect_10,
	input wire polarity_inverted_det,
	input wire selftest_start,
	input wire selftest_nibble_err,
	input wire selftest_result_valid,
	input wire selftest_result_pass,
	input wire pattern_seq_done,
	output reg [15:0] reg_rdata,
	output reg [2:0] squelch_code,
	output reg tx_echo_en,
	output reg nlp_tx_en,
	output reg link_good_10,
	output reg polarity_flag,
	output reg sqe_test_en,
	output reg overlong_tx_guard_en,
	output reg selftest_continuous,
	output reg selftest_pass_flag,
	output reg normal_tx_10_en,
	output reg slow_test_pattern_active,
	output reg [1:0] test_pattern_select,
	output wire pattern_seq_start,
	output wire pattern_gap_busy
);

	// cycle counts are worked out in integer range and cut to the counter width on purpose
	localparam integer GAP_SHORT_INT =
		(`TBT_GAP_SHORT_NS + `TBT_CLK_PERIOD_NS - 1) / `TBT_CLK_PERIOD_NS;
	localparam integer GAP_LONG_INT =
		(`TBT_GAP_LONG_NS + `TBT_CLK_PERIOD_NS - 1) / `TBT_CLK_PERIOD_NS;
	localparam [`TBT_GAP_CNT_W-1:0] GAP_SHORT_CYC = GAP_SHORT_INT[`TBT_GAP_CNT_W-1:0];
	localparam [`TBT_GAP_CNT_W-1:0] GAP_LONG_CYC = GAP_LONG_INT[`TBT_GAP_CNT_W-1:0];

	function addr_hit;
		input [`TBT_ADDR_W-1:0] addr;
		input [`TBT_ADDR_W-1:0] ofs;
		begin
			addr_hit = (addr == ofs);
		end
	endfunction

	reg [15:0] cs_reg;
	reg [15:0] px_reg;
	reg polarity_reg;
	reg start_d_reg;
	wire [7:0] err_count;
	wire cs_sel;
	wire px_sel;
	wire restart;
	wire ten_meg;
	wire pat_en;

	assign cs_sel = addr_hit(reg_addr, `TBT_OFS_CTRL_STATUS);
	assign px_sel = addr_hit(reg_addr, `TBT_OFS_PATTERN_EXT);
	assign restart = selftest_start & ~start_d_reg;
	assign ten_meg = ~speed_100;
	assign pat_en = px_reg[`TBT_PAT_EN_BIT];

	////////////////////////////////////////////////////////////////////////////
	// writable storage
	// reserved bits are plain storage; software is trusted to keep bit 2 high
	// and the rest low, so no hardware forcing is done here
	always @(posedge clk)
	begin
		if (srst)
		begin
			cs_reg <= `TBT_CS_RESET;
			px_reg <= `TBT_PX_RESET;
		end
		else if (clk_en && reg_wr_en)
		begin
			if (cs_sel)
			begin
				cs_reg <= (cs_reg & ~`TBT_CS_WR_MASK) | (reg_wdata & `TBT_CS_WR_MASK);
			end
			if (px_sel)
			begin
				px_reg <= (px_reg & ~`TBT_PX_WR_MASK) | (reg_wdata & `TBT_PX_WR_MASK);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// latched-high polarity; a detect in the clearing read's cycle wins
	always @(posedge clk)
	begin
		if (srst)
		begin
			polarity_reg <= 1'b0;
		end
		else if (clk_en)
		begin
			if (polarity_inverted_det)
			begin
				polarity_reg <= 1'b1;
			end
			else if (reg_rd_en && cs_sel)
			begin
				polarity_reg <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read port; the status-register mirror has no read path here, so its
	// reads cannot disturb the flag
	always @(posedge clk)
	begin
		if (srst)
		begin
			reg_rdata <= 16'h0000;
		end
		else if (clk_en && reg_rd_en)
		begin
			if (cs_sel)
			begin
				reg_rdata <= {cs_reg[15:5], polarity_reg, cs_reg[3:0]};
			end
			else if (px_sel)
			begin
				reg_rdata <= {err_count, px_reg[7:0]};
			end
			else
			begin
				reg_rdata <= 16'h0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// self-test support
	always @(posedge clk)
	begin
		if (srst)
		begin
			start_d_reg <= 1'b0;
			selftest_pass_flag <= 1'b0;
		end
		else if (clk_en)
		begin
			start_d_reg <= selftest_start;
			if (!selftest_start)
			begin
				selftest_pass_flag <= 1'b0;
			end
			else if (selftest_result_valid)
			begin
				selftest_pass_flag <= selftest_result_pass;
			end
		end
	end

	tbt_err_cnt #(
		.WIDTH(8)
	) u_err_cnt (
		.clk(clk),
		.srst(srst),
		.clk_en(clk_en),
		.restart(restart),
		.run(selftest_start),
		.err(selftest_nibble_err),
		.count_reg(err_count)
	);

	////////////////////////////////////////////////////////////////////////////
	// 10 Mb test-pattern sequencing
	tbt_gap_timer #(
		.CNT_W(`TBT_GAP_CNT_W),
		.SHORT_CYC(GAP_SHORT_CYC),
		.LONG_CYC(GAP_LONG_CYC)
	) u_gap (
		.clk(clk),
		.srst(srst),
		.clk_en(clk_en),
		.enable(pat_en),
		.long_sel(px_reg[`TBT_GAP_SEL_BIT]),
		.seq_done(pattern_seq_done),
		.seq_start_reg(pattern_seq_start),
		.gap_busy_reg(pattern_gap_busy)
	);

	////////////////////////////////////////////////////////////////////////////
	// registered control outputs toward the analog and PCS blocks
	always @(posedge clk)
	begin
		if (srst)
		begin
			squelch_code <= 3'h4;
			tx_echo_en <= 1'b0;
			nlp_tx_en <= 1'b0;
			link_good_10 <= 1'b0;
			polarity_flag <= 1'b0;
			sqe_test_en <= 1'b0;
			overlong_tx_guard_en <= 1'b0;
			selftest_continuous <= 1'b0;
			normal_tx_10_en <= 1'b0;
			slow_test_pattern_active <= 1'b0;
			test_pattern_select <= 2'h0;
		end
		else if (clk_en)
		begin
			squelch_code <= cs_reg[`TBT_SQUELCH_HI:`TBT_SQUELCH_LO];
			// echo gating only; general loopback is muxed elsewhere
			tx_echo_en <= half_duplex & ten_meg & ~cs_reg[`TBT_ECHO_DIS_BIT];
			nlp_tx_en <= ten_meg & ~cs_reg[`TBT_NLP_DIS_BIT] & ~pat_en;
			link_good_10 <= cs_reg[`TBT_FORCE_LINK_BIT] | link_detect_10;
			polarity_flag <= polarity_reg;
			sqe_test_en <= half_duplex & ten_meg & ~cs_reg[`TBT_SQE_DIS_BIT];
			overlong_tx_guard_en <= ten_meg & ~cs_reg[`TBT_GUARD_DIS_BIT];
			selftest_continuous <= selftest_start & px_reg[`TBT_CONT_BIT];
			normal_tx_10_en <= ten_meg & ~pat_en;
			slow_test_pattern_active <= pat_en;
			test_pattern_select <= pat_en ? px_reg[`TBT_PAT_SEL_HI:`TBT_PAT_SEL_LO]
				: `TBT_PAT_EOP0;
		end
	end

endmodule

`default_nettype wire

// ### verification/tb_tbt_regs.sv
// self-checking bench for the register pair
// assumes tbt_regs, its header and the management model
`timescale 1ns/1ps
`default_nettype none
`include "tbt_map.vh"
module tb_tbt_regs;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic clk_en = 1'b1;
	logic half_duplex = 1'b0;
	logic speed_100 = 1'b0;
	logic link_detect_10 = 1'b0;
	logic polarity_inverted_det = 1'b0;
	logic selftest_start = 1'b0;
	logic selftest_nibble_err = 1'b0;
	logic selftest_result_valid = 1'b0;
	logic selftest_result_pass = 1'b0;
	logic pattern_seq_done = 1'b0;
	wire [4:0] reg_addr;
	wire [15:0] reg_wdata, reg_rdata;
	wire [2:0] squelch_code;
	wire [1:0] test_pattern_select;
	wire reg_wr_en, reg_rd_en, tx_echo_en, nlp_tx_en, link_good_10, polarity_flag;
	wire sqe_test_en, overlong_tx_guard_en, selftest_continuous, selftest_pass_flag;
	wire normal_tx_10_en, slow_test_pattern_active, pattern_seq_start, pattern_gap_busy;
	int num_errors = 0;
	int checks_done = 0;
	int i;
	int n;
	logic [31:0] v;
	logic [15:0] d;
	tbt_regs uut (.clk, .srst, .clk_en, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata,
		.half_duplex, .speed_100, .link_detect_10, .polarity_inverted_det,
		.selftest_start, .selftest_nibble_err, .selftest_result_valid,
		.selftest_result_pass, .pattern_seq_done, .reg_rdata, .squelch_code,
		.tx_echo_en, .nlp_tx_en, .link_good_10, .polarity_flag, .sqe_test_en,
		.overlong_tx_guard_en, .selftest_continuous, .selftest_pass_flag,
		.normal_tx_10_en, .slow_test_pattern_active, .test_pattern_select,
		.pattern_seq_start, .pattern_gap_busy);
	tbt_mgmt_model mgmt (.clk, .reg_rdata, .reg_addr, .reg_wr_en, .reg_rd_en, .reg_wdata);
	always #25 clk = ~clk;
	////////////////////////////////////////////////////////////////////////////////
	task chk(input string what, input [15:0] seen, input [15:0] exp);
	begin
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	end
	endtask
	task summarize;
	begin
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end
	endtask
	// run takes roughly 1000 cycles; the limit leaves wide margin
	initial
	begin
		#1000000;
		num_errors++;
		summarize;
	end
	initial
	begin
		v = $urandom(90);
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		mgmt.rd(`TBT_OFS_CTRL_STATUS, d);
		chk("cs reset", d, 16'h0804);
		mgmt.rd(`TBT_OFS_PATTERN_EXT, d);
		chk("px reset", d, 16'h0000);
		mgmt.rd(5'h05, d);
		chk("unmapped", d, 16'h0000);
		repeat (20)
		begin
			v = $urandom;
			half_duplex <= v[12];
			speed_100 <= v[13];
			link_detect_10 <= v[14];
			mgmt.wr(`TBT_OFS_CTRL_STATUS, v[15:0]);
			mgmt.rd(`TBT_OFS_CTRL_STATUS, d);
			chk("cs rdback", d, (v[15:0] & 16'h0FC3) | 16'h0004);
			chk("cs ctl", {tx_echo_en, nlp_tx_en, sqe_test_en, overlong_tx_guard_en,
				link_good_10, squelch_code}, {v[12] & ~v[13] & ~v[8], ~v[13] & ~v[7],
				v[12] & ~v[13] & ~v[1], ~v[13] & ~v[0], v[6] | v[14], v[11:9]});
		end
		polarity_inverted_det <= 1'b1;
		@(posedge clk);
		polarity_inverted_det <= 1'b0;
		mgmt.rd(`TBT_OFS_PATTERN_EXT, d);
		chk("pol kept", polarity_flag, 1'b1);
		mgmt.rd(`TBT_OFS_CTRL_STATUS, d);
		chk("pol bit", d[4], 1'b1);
		mgmt.rd(`TBT_OFS_CTRL_STATUS, d);
		chk("pol clr", {d[4], polarity_flag}, 2'b00);
		// a write while clock enable is low must leave the register untouched
		clk_en <= 1'b0;
		mgmt.wr(`TBT_OFS_CTRL_STATUS, ~v[15:0]);
		clk_en <= 1'b1;
		mgmt.rd(`TBT_OFS_CTRL_STATUS, d);
		chk("frozen", d, (v[15:0] & 16'h0FC3) | 16'h0004);
		for (i = 0; i < 8; i++)
		begin
			v = $urandom;
			v[4] = i[2];
			v[1:0] = i[1:0];
			mgmt.wr(`TBT_OFS_PATTERN_EXT, v[15:0]);
			mgmt.rd(`TBT_OFS_PATTERN_EXT, d);
			chk("px rdback", d, v[15:0] & 16'h0037);
			chk("pattern", {slow_test_pattern_active, normal_tx_10_en, test_pattern_select},
				{v[4], ~v[4] & ~speed_100, v[4] ? v[1:0] : 2'b00});
		end
		for (i = 0; i < 2; i++)
		begin
			mgmt.wr(`TBT_OFS_PATTERN_EXT, 16'h0000);
			mgmt.wr(`TBT_OFS_PATTERN_EXT, {13'h0000, i[0], 2'b00} | 16'h0010);
			n = 0;
			while (pattern_seq_start !== 1'b1 && n < 20)
			begin
				@(posedge clk);
				n++;
			end
			chk("seq start", pattern_seq_start, 1'b1);
			pattern_seq_done <= 1'b1;
			@(posedge clk);
			pattern_seq_done <= 1'b0;
			n = 0;
			do
			begin
				@(posedge clk);
				n++;
			end
			while (pattern_seq_start !== 1'b1 && n < 400);
			// the start pulse launched at the last gap edge is seen one edge later
			chk("gap", n - 1, i ? 16'h012C : 16'h00C8);
		end
		mgmt.wr(`TBT_OFS_CTRL_STATUS, 16'h0001);
		mgmt.wr(`TBT_OFS_PATTERN_EXT, 16'h0020);
		selftest_start <= 1'b1;
		@(posedge clk);
		selftest_nibble_err <= 1'b1;
		repeat (5) @(posedge clk);
		selftest_nibble_err <= 1'b0;
		mgmt.rd(`TBT_OFS_PATTERN_EXT, d);
		chk("errcnt", d, 16'h0520);
		chk("cont", selftest_continuous, 1'b1);
		selftest_nibble_err <= 1'b1;
		repeat (260) @(posedge clk);
		selftest_nibble_err <= 1'b0;
		selftest_result_pass <= 1'b1;
		selftest_result_valid <= 1'b1;
		@(posedge clk);
		selftest_result_valid <= 1'b0;
		mgmt.rd(`TBT_OFS_PATTERN_EXT, d);
		chk("errsat", d, 16'hFF20);
		chk("pass", selftest_pass_flag, 1'b1);
		selftest_start <= 1'b0;
		repeat (3) @(posedge clk);
		chk("pass clr", selftest_pass_flag, 1'b0);
		selftest_start <= 1'b1;
		mgmt.rd(`TBT_OFS_PATTERN_EXT, d);
		chk("restart", d, 16'h0020);
		summarize;
	end
endmodule
`default_nettype wire

// ### verification/tbt_mgmt_model.sv
// management-side model issuing word strobes to the register pair
// assumes clk_en high while it runs
`timescale 1ns/1ps
`default_nettype none
`include "tbt_map.vh"
module tbt_mgmt_model (
	input wire logic clk,
	input wire logic [15:0] reg_rdata,
	output logic [4:0] reg_addr,
	output logic reg_wr_en,
	output logic reg_rd_en,
	output logic [15:0] reg_wdata
);
	initial
	begin
		reg_addr = 5'h00;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_wdata = 16'h0000;
	end
	task wr(input [4:0] a, input [15:0] d);
	begin
		if (a == `TBT_OFS_CTRL_STATUS)
			d = (d & 16'h0FC3) | 16'h0004;
		else if (a == `TBT_OFS_PATTERN_EXT)
			d = d & 16'h0037;
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr_en <= 1'b1;
		@(posedge clk);
		reg_wr_en <= 1'b0;
		// released data must not keep looking valid
		reg_wdata <= ~d;
	end
	endtask
	task rd(input [4:0] a, output [15:0] d);
	begin
		@(posedge clk);
		reg_addr <= a;
		reg_rd_en <= 1'b1;
		@(posedge clk);
		reg_rd_en <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
	end
	endtask
endmodule
`default_nettype wire

// ### verification/tbt_regs_props.sv
// port-level assertions for the 10BASE-T control and test-pattern registers
// assumes bind into tbt_regs and clk_en held high while a gap runs
`timescale 1ns/1ps
`default_nettype none
`include "tbt_map.vh"
module tbt_regs_props (
	input wire clk,
	input wire srst,
	input wire clk_en,
	input wire [`TBT_ADDR_W-1:0] reg_addr,
	input wire reg_rd_en,
	input wire half_duplex,
	input wire speed_100,
	input wire link_detect_10,
	input wire polarity_inverted_det,
	input wire link_good_10,
	input wire polarity_flag,
	input wire sqe_test_en,
	input wire overlong_tx_guard_en,
	input wire slow_test_pattern_active,
	input wire [1:0] test_pattern_select,
	input wire pattern_seq_start,
	input wire pattern_gap_busy
);
	wire rd_cs = reg_rd_en && reg_addr == `TBT_OFS_CTRL_STATUS;
	reg [8:0] busy_len;
	// length of the current gap in sampled cycles
	always @(posedge clk)
		busy_len <= (srst || !pattern_gap_busy) ? 9'h000 : busy_len + 9'h001;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	a_link_follows_detect: assert property (clk_en && link_detect_10 |=> link_good_10)
		else $error("link good missing");
	a_guard_off_fast: assert property (clk_en && speed_100 |=> !overlong_tx_guard_en)
		else $error("guard on at 100 Mb");
	a_sqe_off_full: assert property (clk_en && (speed_100 || !half_duplex) |=> !sqe_test_en)
		else $error("heartbeat on outside half 10");
	a_pol_latch_set: assert property (clk_en && polarity_inverted_det |-> ##[1:2] polarity_flag)
		else $error("polarity not latched");
	a_pol_read_hold: assert property (polarity_flag && !rd_cs && !$past(rd_cs) |=> polarity_flag)
		else $error("polarity lost without read");
	a_pol_read_clear: assert property (clk_en && rd_cs && !polarity_inverted_det
		##1 (clk_en && !polarity_inverted_det) |=> !polarity_flag)
		else $error("polarity not cleared by read");
	a_pat_sel_gated: assert property (!slow_test_pattern_active
		|-> test_pattern_select == `TBT_PAT_EOP0)
		else $error("pattern select leaks");
	a_gap_span_len: assert property (pattern_seq_start && $past(pattern_gap_busy)
		|-> busy_len == 9'h0C8 || busy_len == 9'h12C)
		else $error("gap length wrong");
	c_seq_start: cover property (pattern_seq_start);
	c_pol_read: cover property (rd_cs && polarity_flag);
	c_gap_end: cover property (pattern_gap_busy ##1 pattern_seq_start);
endmodule
bind tbt_regs tbt_regs_props u_props (.clk, .srst, .clk_en, .reg_addr, .reg_rd_en,
	.half_duplex, .speed_100, .link_detect_10, .polarity_inverted_det, .link_good_10,
	.polarity_flag, .sqe_test_en, .overlong_tx_guard_en, .slow_test_pattern_active,
	.test_pattern_select, .pattern_seq_start, .pattern_gap_busy);
`default_nettype wire
